// [rtl/rad_cfg.svh]
// constants for the register access command decoder
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef RAD_CFG_SVH
`define RAD_CFG_SVH

// bus offsets (byte addresses)
`define RAD_OFS_CMD        8'h00
`define RAD_OFS_DATA       8'h04
`define RAD_OFS_STAT       8'h08

// command byte fields
`define RAD_CMD_START_BIT  7
`define RAD_CMD_DIR_BIT    6
`define RAD_CMD_ADDR_MSB   5
`define RAD_CMD_RESET      8'h00

// status word fields
`define RAD_STAT_BAD_BIT   8
`define RAD_STAT_PEND_BIT  7
`define RAD_STAT_DIR_BIT   6

// address map regions
`define RAD_ADDR_RSV_CORE  6'h05
`define RAD_ADDR_CHAN_HI   2'b01
`define RAD_ADDR_SETUP_HI  3'b100
`define RAD_ADDR_FILT_HI   3'b101
`define RAD_ADDR_OFFS_HI   3'b110
`define RAD_ADDR_GAIN_HI   3'b111

`endif

// [rtl/rad_pkg.sv]
// types shared by the command decoder files
package rad_pkg;

  // target register group, one-hot
  typedef enum logic [6:0]
  {
    RAD_GRP_CORE  = 7'h01,
    RAD_GRP_CHAN  = 7'h02,
    RAD_GRP_SETUP = 7'h04,
    RAD_GRP_FILT  = 7'h08,
    RAD_GRP_OFFS  = 7'h10,
    RAD_GRP_GAIN  = 7'h20,
    RAD_GRP_RSV   = 7'h40
  } rad_grp_e;

  // bus slave sequencing, one-hot
  typedef enum logic [2:0]
  {
    RAD_BUS_IDLE  = 3'h1,
    RAD_BUS_RDLOC = 3'h2,
    RAD_BUS_RDTGT = 3'h4
  } rad_bus_e;

endpackage

// [rtl/rad_addr_map.sv]
// classifies a 6-bit target address into a register group and index
`timescale 1ns/10ps
`default_nettype none
`include "rad_cfg.svh"

module rad_addr_map
(
  input  wire logic             clk,    // system clock
  input  wire logic             rst_n,  // async reset, active low
  input  wire logic             load,   // capture a new address
  input  wire logic [5:0]       addr,   // target address from command
  output rad_pkg::rad_grp_e     grp,    // registered group
  output logic      [3:0]       idx     // registered index in group
);
  import rad_pkg::*;

  rad_grp_e   next_grp;
  logic [3:0] next_idx;

  // region decode of one address
  function automatic rad_grp_e classify(input logic [5:0] a);
    rad_grp_e g;
    g = RAD_GRP_RSV;
    if (a[5:3] == 3'b000 && a != `RAD_ADDR_RSV_CORE)
      g = RAD_GRP_CORE;
    else if (a[5:4] == `RAD_ADDR_CHAN_HI)
      g = RAD_GRP_CHAN;
    else if (a[5:3] == `RAD_ADDR_SETUP_HI)
      g = RAD_GRP_SETUP;
    else if (a[5:3] == `RAD_ADDR_FILT_HI)
      g = RAD_GRP_FILT;
    else if (a[5:3] == `RAD_ADDR_OFFS_HI)
      g = RAD_GRP_OFFS;
    else if (a[5:3] == `RAD_ADDR_GAIN_HI)
      g = RAD_GRP_GAIN;
    return g;
  endfunction

  // next group and index; channels use four index bits, others three
  always_comb
  begin
    next_grp = grp;
    next_idx = idx;
    if (load)
    begin
      next_grp = classify(addr);
      next_idx = (addr[5:4] == `RAD_ADDR_CHAN_HI) ? addr[3:0] : {1'b0, addr[2:0]};
    end
  end

  // registered so the top drives its outputs from flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      grp <= RAD_GRP_CORE;
      idx <= 4'h0;
    end
    else
    begin
      grp <= next_grp;
      idx <= next_idx;
    end
  end

endmodule
`default_nettype wire

// [rtl/rad_cmd_decoder.sv]
// ahb-lite command byte decoder steering one access to a target register
`timescale 1ns/10ps
`default_nettype none
`include "rad_cfg.svh"

module rad_cmd_decoder
(
  input  wire logic             hclk,        // bus clock, 125 MHz
  input  wire logic             hresetn,     // async reset, active low
  input  wire logic             hsel,        // slave select
  input  wire logic [31:0]      haddr,       // byte address
  input  wire logic [1:0]       htrans,      // transfer type
  input  wire logic             hwrite,      // write when high
  input  wire logic [2:0]       hsize,       // word only
  input  wire logic [31:0]      hwdata,      // write data
  input  wire logic             hready,      // bus ready in
  output logic                  hreadyout,   // slave ready
  output logic                  hresp,       // always okay
  output logic      [31:0]      hrdata,      // read data
  output logic                  tgt_wr,      // one-cycle target write
  output logic                  tgt_rd,      // target read request
  output logic      [5:0]       target_reg_addr, // addressed register
  output logic      [31:0]      tgt_wdata,   // target write data
  input  wire logic [31:0]      tgt_rdata,   // target read data
  output rad_pkg::rad_grp_e     tgt_grp,     // target group
  output logic      [3:0]       tgt_idx      // index within group
);
  import rad_pkg::*;

  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  rad_bus_e    bus_st, next_bus_st;
  logic        dp_wr, next_dp_wr;          // write data phase pending
  logic [2:0]  dp_sel, next_dp_sel;        // {stat, data, cmd}
  logic        pend, next_pend;            // command held, awaiting access
  logic        cmd_rd, next_cmd_rd;        // held direction
  logic [5:0]  cmd_addr, next_cmd_addr;    // held address
  logic        bad_cmd, next_bad_cmd;      // sticky rejected command
  logic        next_hreadyout;
  logic [31:0] next_hrdata;
  logic        next_tgt_wr;
  logic        next_tgt_rd;
  logic [5:0]  next_tgt_addr;
  logic [31:0] next_tgt_wdata;
  logic        map_load;
  logic        addr_go;
  logic        cmd_fire;
  logic        data_fire;
  logic        tgt_rsv;

  // address phase decode, upper address bits must be zero to hit
  function automatic logic [2:0] reg_sel(input logic [31:0] a);
    logic [2:0] s;
    s = 3'b000;
    if (a[31:8] == 24'h000000)
    begin
      if (a[7:0] == `RAD_OFS_CMD)
        s = 3'b001;
      else if (a[7:0] == `RAD_OFS_DATA)
        s = 3'b010;
      else if (a[7:0] == `RAD_OFS_STAT)
        s = 3'b100;
    end
    return s;
  endfunction

  assign addr_go   = hsel && htrans[1] && hready;
  assign cmd_fire  = dp_wr && dp_sel[0];
  assign data_fire = dp_wr && dp_sel[1];
  assign tgt_rsv   = (tgt_grp == RAD_GRP_RSV);

  //----------------------------------------------------------------------------
  // group classifier, loaded with each accepted command
  //----------------------------------------------------------------------------
  rad_addr_map u_map
  (
    .clk   (hclk),
    .rst_n (hresetn),
    .load  (map_load),
    .addr  (hwdata[`RAD_CMD_ADDR_MSB:0]),
    .grp   (tgt_grp),
    .idx   (tgt_idx)
  );

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------
  // reads cost one wait state, target data reads two, so they see every earlier write's effect
  always_comb
  begin
    next_bus_st    = bus_st;
    next_dp_wr     = 1'b0;
    next_dp_sel    = dp_sel;
    next_pend      = pend;
    next_cmd_rd    = cmd_rd;
    next_cmd_addr  = cmd_addr;
    next_bad_cmd   = bad_cmd;
    next_hreadyout = hreadyout;
    next_hrdata    = hrdata;
    next_tgt_wr    = 1'b0;
    next_tgt_rd    = tgt_rd;
    next_tgt_addr  = target_reg_addr;
    next_tgt_wdata = tgt_wdata;
    map_load       = 1'b0;

    // address phase
    if (addr_go)
    begin
      next_dp_sel = reg_sel(haddr);
      next_dp_wr  = hwrite;
      if (!hwrite)
      begin
        next_bus_st    = RAD_BUS_RDLOC;
        next_hreadyout = 1'b0;
      end
    end

    // read completion
    unique case (bus_st)
      RAD_BUS_IDLE:
        next_hrdata = hrdata;
      RAD_BUS_RDLOC:
      begin
        next_hrdata    = 32'h00000000;     // command byte reads zero
        next_hreadyout = 1'b1;
        next_bus_st    = RAD_BUS_IDLE;
        if (dp_sel[2])
        begin
          next_hrdata  = {23'h000000, bad_cmd, pend, cmd_rd, cmd_addr};
          next_bad_cmd = 1'b0;             // clear on read, set below wins
        end
        if (dp_sel[1])
        begin
          next_pend = 1'b0;                // access consumed, back to idle
          if (pend && cmd_rd && !tgt_rsv)  // read routed to target
          begin
            next_tgt_rd    = 1'b1;
            next_tgt_addr  = cmd_addr;
            next_hreadyout = 1'b0;
            next_bus_st    = RAD_BUS_RDTGT;
          end
        end
      end
      RAD_BUS_RDTGT:
      begin
        next_hrdata    = tgt_rdata;
        next_tgt_rd    = 1'b0;
        next_hreadyout = 1'b1;
        next_bus_st    = RAD_BUS_IDLE;
      end
    endcase

    // write data phase: command byte
    if (cmd_fire)
    begin
      if (!hwdata[`RAD_CMD_START_BIT])     // start qualifier low
      begin
        next_pend     = 1'b1;
        next_cmd_rd   = hwdata[`RAD_CMD_DIR_BIT];
        next_cmd_addr = hwdata[`RAD_CMD_ADDR_MSB:0];
        map_load      = 1'b1;
      end
      else
        next_bad_cmd = 1'b1;               // ignored, decoder state kept
    end

    // write data phase: data word
    if (data_fire)
    begin
      next_pend = 1'b0;
      if (pend && !cmd_rd && !tgt_rsv)     // reserved targets get nothing
      begin
        next_tgt_wr    = 1'b1;
        next_tgt_addr  = cmd_addr;
        next_tgt_wdata = hwdata;
      end
    end
  end

  //----------------------------------------------------------------------------
  // registers
  //----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_st          <= RAD_BUS_IDLE;
      dp_wr           <= 1'b0;
      dp_sel          <= 3'b000;
      pend            <= 1'b0;
      cmd_rd          <= 1'(`RAD_CMD_RESET >> `RAD_CMD_DIR_BIT);
      cmd_addr        <= 6'h00;
      bad_cmd         <= 1'b0;
      hreadyout       <= 1'b1;
      hresp           <= 1'b0;
      hrdata          <= 32'h00000000;
      tgt_wr          <= 1'b0;
      tgt_rd          <= 1'b0;
      target_reg_addr <= 6'h00;
      tgt_wdata       <= 32'h00000000;
    end
    else
    begin
      bus_st          <= next_bus_st;
      dp_wr           <= next_dp_wr;
      dp_sel          <= next_dp_sel;
      pend            <= next_pend;
      cmd_rd          <= next_cmd_rd;
      cmd_addr        <= next_cmd_addr;
      bad_cmd         <= next_bad_cmd;
      hreadyout       <= next_hreadyout;
      hresp           <= 1'b0;             // single okay response only
      hrdata          <= next_hrdata;
      tgt_wr          <= next_tgt_wr;
      tgt_rd          <= next_tgt_rd;
      target_reg_addr <= next_tgt_addr;
      tgt_wdata       <= next_tgt_wdata;
    end
  end

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  chk_bad_cmd_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_fire && hwdata[7] |=> bad_cmd && $stable(cmd_addr) && !tgt_wr)
    else $error("command with start bit set was not ignored");

  chk_good_cmd_held: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_fire && !hwdata[7] |=> pend && cmd_addr == $past(hwdata[5:0]))
    else $error("valid command address not held");

  chk_dir_decode: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_fire && !hwdata[7] |=> cmd_rd == $past(hwdata[6]))
    else $error("command direction decoded wrongly");

  chk_tgt_write: assert property (@(posedge hclk) disable iff (!hresetn)
    data_fire && pend && !cmd_rd && !tgt_rsv
      |=> tgt_wr && target_reg_addr == $past(cmd_addr) && tgt_wdata == $past(hwdata))
    else $error("data write not routed to addressed register");

  chk_back_to_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    data_fire ##1 !cmd_fire |-> !pend)
    else $error("decoder did not return to idle after access");

  chk_tgt_read: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(tgt_rd) |-> !hreadyout ##1 (hreadyout && !tgt_rd))
    else $error("target read did not complete in one wait state");

  chk_map_chan: assert property (@(posedge hclk) disable iff (!hresetn)
    pend && cmd_addr[5:4] == 2'b01 |-> tgt_grp == RAD_GRP_CHAN && tgt_idx == cmd_addr[3:0])
    else $error("channel address mapped wrongly");

  chk_map_gain: assert property (@(posedge hclk) disable iff (!hresetn)
    pend && cmd_addr[5:3] == 3'b111 |-> tgt_grp == RAD_GRP_GAIN && tgt_idx == {1'b0, cmd_addr[2:0]})
    else $error("gain address mapped wrongly");

  chk_map_core: assert property (@(posedge hclk) disable iff (!hresetn)
    pend && cmd_addr[5:3] == 3'b000 && cmd_addr != 6'h05 |-> tgt_grp == RAD_GRP_CORE)
    else $error("core address mapped wrongly");

  chk_rsv_no_effect: assert property (@(posedge hclk) disable iff (!hresetn)
    pend && tgt_rsv |-> ##1 (!tgt_wr && !$rose(tgt_rd)))
    else $error("reserved address reached a target");

endmodule
`default_nettype wire

// [tb/rad_tgt_model.sv]
// target register model on the decoder's far side
`timescale 1ns/10ps
`default_nettype none

module rad_tgt_model
(
  input  wire logic        hclk,            // bus clock
  input  wire logic        tgt_wr,          // write strobe
  input  wire logic        tgt_rd,          // read request
  input  wire logic [5:0]  target_reg_addr, // register address
  input  wire logic [31:0] tgt_wdata,       // write data
  output logic      [31:0] tgt_rdata        // read data
);
  logic [31:0] mem [64];
  logic [31:0] junk = 32'h0;

  // store writes; junk moves every cycle so stale data never looks valid
  always_ff @(posedge hclk)
  begin
    junk <= ~junk ^ 32'h5a5a0001;
    if (tgt_wr)
      mem[target_reg_addr] <= tgt_wdata;
  end

  // data only while a read is requested
  assign tgt_rdata = tgt_rd ? mem[target_reg_addr] : junk;
endmodule
`default_nettype wire

// [tb/tb_register_access_command_decoder.sv]
// self-checking bench for the command decoder
`timescale 1ns/10ps
`default_nettype none
`include "rad_cfg.svh"

module tb_register_access_command_decoder;
  import rad_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, tgt_wr, tgt_rd;
  logic [31:0] haddr, hwdata, hrdata, tgt_wdata, tgt_rdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  target_reg_addr;
  logic [3:0]  tgt_idx;
  rad_grp_e    tgt_grp;
  int          errors = 0, n_checks = 0, wr_cnt = 0, rd_cnt = 0, cyc = 0;
  logic [5:0]  alist [18] = '{0, 1, 2, 3, 4, 6, 7, 16, 23, 31, 32, 39, 40, 47, 48, 55, 56, 63};

  rad_cmd_decoder DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tgt_wr(tgt_wr), .tgt_rd(tgt_rd),
    .target_reg_addr(target_reg_addr), .tgt_wdata(tgt_wdata), .tgt_rdata(tgt_rdata),
    .tgt_grp(tgt_grp), .tgt_idx(tgt_idx));
  rad_tgt_model far (.hclk(hclk), .tgt_wr(tgt_wr), .tgt_rd(tgt_rd),
    .target_reg_addr(target_reg_addr), .tgt_wdata(tgt_wdata), .tgt_rdata(tgt_rdata));

  //----------------------------------------------------------------------------
  // clock, strobe counters and hang guard
  //----------------------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // strobes are counted so a doubled or missing pulse shows up
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (tgt_wr === 1'b1)
      wr_cnt <= wr_cnt + 1;
    if (tgt_rd === 1'b1)
      rd_cnt <= rd_cnt + 1;
    if (cyc == 5000)
    begin
      errors = errors + 1;
      test_done();
    end
  end

  //----------------------------------------------------------------------------
  // shared tasks
  //----------------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // one single word transfer; waits on hready, never a fixed count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    rd = hrdata;
  endtask

  // lets a target strobe land and be counted
  task automatic settle();
    repeat (2) @(posedge hclk);
  endtask

  function automatic rad_grp_e grp_of(input logic [5:0] a);
    case (a[5:3])
      3'b000:  return (a == 6'h05) ? RAD_GRP_RSV : RAD_GRP_CORE;
      3'b001:  return RAD_GRP_RSV;
      3'b010:  return RAD_GRP_CHAN;
      3'b011:  return RAD_GRP_CHAN;
      3'b100:  return RAD_GRP_SETUP;
      3'b101:  return RAD_GRP_FILT;
      3'b110:  return RAD_GRP_OFFS;
      default: return RAD_GRP_GAIN;
    endcase
  endfunction

  //----------------------------------------------------------------------------
  // scenarios
  //----------------------------------------------------------------------------
  task automatic t_reset();
    chk(hreadyout === 1'b1 && hresp === 1'b0 && tgt_wr === 1'b0, "bus idle");
    chk(tgt_grp === RAD_GRP_CORE && target_reg_addr === 6'h00, "reset target");
    bus(1'b1, `RAD_OFS_CMD, 32'h0000ff13);
    bus(1'b0, `RAD_OFS_CMD, 32'h0);
    chk(rd === 32'h0, "command reads back");
    $display("test reset done");
  endtask

  // every non-reserved group and its edges, written then read back through the far side
  task automatic t_map();
    int n;
    logic [5:0] a;
    logic [31:0] d;
    foreach (alist[i])
    begin
      a = alist[i];
      d = {8'ha5, 2'b00, a, 16'h1234};
      bus(1'b1, `RAD_OFS_CMD, {24'h0, 2'b00, a});
      settle();
      chk(tgt_grp === grp_of(a), "group");
      chk(tgt_idx === (a[5:4] == 2'b01 ? a[3:0] : {1'b0, a[2:0]}), "index");
      n = wr_cnt;
      bus(1'b1, `RAD_OFS_DATA, d);
      settle();
      chk(wr_cnt == n + 1 && target_reg_addr === a && tgt_wdata === d, "write");
      bus(1'b1, `RAD_OFS_CMD, {24'h0, 2'b01, a});
      n = rd_cnt;
      bus(1'b0, `RAD_OFS_DATA, 32'h0);
      chk(rd === d && rd_cnt == n + 1, "read");
      bus(1'b0, `RAD_OFS_DATA, 32'h0);
      chk(rd === 32'h0 && rd_cnt == n + 1, "second read");
    end
    $display("test map done");
  endtask

  // a byte with the start bit set is dropped and the pending one kept
  task automatic t_bad();
    int n;
    bus(1'b1, `RAD_OFS_CMD, 32'h00000021);
    bus(1'b1, `RAD_OFS_CMD, 32'h000000c4);
    bus(1'b0, `RAD_OFS_STAT, 32'h0);
    chk(rd[8:0] === 9'h1a1, "status after bad");
    bus(1'b0, `RAD_OFS_STAT, 32'h0);
    chk(rd[8:0] === 9'h0a1, "status cleared");
    n = wr_cnt;
    bus(1'b1, `RAD_OFS_DATA, 32'h0badf00d);
    settle();
    chk(wr_cnt == n + 1 && target_reg_addr === 6'h21, "kept command");
    bus(1'b1, `RAD_OFS_CMD, 32'h00000090);
    bus(1'b1, `RAD_OFS_DATA, 32'h1);
    settle();
    chk(wr_cnt == n + 1, "bad alone routes nothing");
    $display("test bad done");
  endtask

  // reserved holes accept a command but route nothing
  task automatic t_rsv();
    int n;
    logic [5:0] r [3] = '{6'h05, 6'h08, 6'h0f};
    foreach (r[i])
    begin
      n = wr_cnt;
      bus(1'b1, `RAD_OFS_CMD, {24'h0, 2'b00, r[i]});
      bus(1'b1, `RAD_OFS_DATA, 32'hffffffff);
      settle();
      chk(wr_cnt == n && tgt_grp === RAD_GRP_RSV, "reserved write");
      n = rd_cnt;
      bus(1'b1, `RAD_OFS_CMD, {24'h0, 2'b01, r[i]});
      bus(1'b0, `RAD_OFS_DATA, 32'h0);
      chk(rd === 32'h0 && rd_cnt == n, "reserved read");
    end
    $display("test reserved done");
  endtask

  // wrong direction consumes the command; a newer command replaces an older
  task automatic t_dir();
    int n;
    int m;
    n = wr_cnt;
    m = rd_cnt;
    bus(1'b1, `RAD_OFS_CMD, 32'h00000010);
    bus(1'b0, `RAD_OFS_DATA, 32'h0);
    chk(rd === 32'h0 && rd_cnt == m, "read on write command");
    bus(1'b1, `RAD_OFS_DATA, 32'h77);
    settle();
    chk(wr_cnt == n, "consumed command");
    bus(1'b1, `RAD_OFS_CMD, 32'h00000011);
    bus(1'b1, `RAD_OFS_CMD, 32'h00000012);
    bus(1'b1, `RAD_OFS_DATA, 32'h55);
    settle();
    chk(wr_cnt == n + 1 && target_reg_addr === 6'h12, "replaced command");
    $display("test direction done");
  endtask

  // reset in mid-run drops a pending command, so the next data word goes nowhere
  task automatic t_midreset();
    int n;
    bus(1'b1, `RAD_OFS_CMD, 32'h00000025);
    bus(1'b0, `RAD_OFS_STAT, 32'h0);
    chk(rd[7:0] === 8'ha5, "pending before reset");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(hreadyout === 1'b1 && tgt_wr === 1'b0 && tgt_rd === 1'b0, "idle in reset");
    hresetn <= 1'b1;
    chk(tgt_grp === RAD_GRP_CORE && target_reg_addr === 6'h00, "target after reset");
    n = wr_cnt;
    bus(1'b1, `RAD_OFS_DATA, 32'h00000042);
    settle();
    chk(wr_cnt == n, "no command after reset");
    bus(1'b0, `RAD_OFS_STAT, 32'h0);
    chk(rd[8:0] === 9'h000, "status after reset");
    $display("test mid reset done");
  endtask

  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_map();
    t_bad();
    t_rsv();
    t_dir();
    t_midreset();
    test_done();
  end
endmodule
`default_nettype wire
